// File: tsense_pkg.sv
// constants and types shared by the register-copy command logic
`default_nettype none
package tsense_pkg;

  // ----------------------------------------------------------------
  // address byte patterns and opcodes
  // ----------------------------------------------------------------
  localparam logic [3:0] SENSOR_TYPE = 4'h9;
  localparam logic [3:0] EE_TYPE = 4'ha;
  localparam logic [7:0] OP_NV2VOL = 8'hb8;
  localparam logic [7:0] OP_VOL2NV = 8'h48;

  // ----------------------------------------------------------------
  // register fields and reset values
  // ----------------------------------------------------------------
  localparam int REG_W = 16;
  localparam int BUSY_POS = 0;
  localparam int LOCK_POS = 1;
  localparam int LOCKDOWN_POS = 2;
  localparam logic [15:0] VOL_RST = 16'h0000;

  // ----------------------------------------------------------------
  // eeprom organisation
  // ----------------------------------------------------------------
  localparam int PAGE_BYTES = 16;
  localparam int EE_BYTES_DEF = 256;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int NV_TO_VOL_COPY_TIME_NS = 200000;
  localparam int VOL_TO_NV_COPY_TIME_NS = 10000000;
  // longest times round down, never below one cycle
  localparam int COPYR_CYC =
    (NV_TO_VOL_COPY_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
    NV_TO_VOL_COPY_TIME_NS / CLK_PERIOD_NS;
  localparam int COPYW_CYC =
    (VOL_TO_NV_COPY_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
    VOL_TO_NV_COPY_TIME_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 18;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_ACK = 2'b10,
    ST_SKIP = 2'b11
  } link_st_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_RD = 2'b01,
    OP_WR = 2'b10
  } copy_op_t;

endpackage
`default_nettype wire

// File: tsense_copy_ctrl.sv
// two-wire target: register-copy commands and eeprom address decode
//
// Summary of operation
// - ack sensor address 1001 plus matching strap bits and write bit.
// - opcode b8 acked; copies nonvolatile config and limits into volatile.
// - opcode 48 acked; copies volatile config and limits into nonvolatile.
// - repeated start instead of stop aborts the copy, nothing changes.
// - busy flag in config stays one while a copy runs.
// - after reset the nonvolatile registers are copied into volatile ones.
// - no copy when busy, lock or lockdown bit is one at opcode.
// - an ignored opcode byte is still acknowledged.
// - eeprom uses 16-byte pages: 16, 32 or 64 pages by density.
// - eeprom byte address is 8, 9 or 10 bits by density.
// - page bits above the word address come from the address byte.
// - address byte: type in bits 7-4, straps or pages 3-1, rw bit 0.
// - eeprom acks only when its used strap bits match the strap pins.
// - an opcode in place of a pointer byte leaves the pointer alone.
// - lock and lockdown bits sit in nonvolatile config and block changes.
`timescale 1ns/100ps
`default_nettype none

module tsense_copy_ctrl #(
  parameter int EE_BYTES = tsense_pkg::EE_BYTES_DEF,
  parameter int COPYR_CYCLES = tsense_pkg::COPYR_CYC,
  parameter int COPYW_CYCLES = tsense_pkg::COPYW_CYC
)(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [2:0] strap_address_bits_in,
  input wire logic [15:0] nv_cfg_in,
  input wire logic [15:0] nv_low_in,
  input wire logic [15:0] nv_high_in,
  input wire logic vol_load_in,
  input wire logic [15:0] vol_cfg_in,
  input wire logic [15:0] vol_low_in,
  input wire logic [15:0] vol_high_in,
  output logic [15:0] vol_cfg_out,
  output logic [15:0] lower_temp_limit_out,
  output logic [15:0] upper_temp_limit_out,
  output logic nv_busy_flag_out,
  output logic nv_write_out,
  output logic ptr_load_out,
  output logic [7:0] ptr_byte_out,
  output logic ee_select_out,
  output logic ee_rw_out,
  output logic [1:0] ee_page_out
);

  // ----------------------------------------------------------------
  // eeprom geometry
  // ----------------------------------------------------------------
  localparam int EE_PB = $clog2(EE_BYTES) - 8;
  localparam int EE_AW = 8 + EE_PB;
  localparam int EE_PAGES = EE_BYTES / tsense_pkg::PAGE_BYTES;
  // page bits take over the low strap positions as density grows
  localparam logic [1:0] PMASK = (EE_PB == 2) ? 2'b11 :
    ((EE_PB == 1) ? 2'b01 : 2'b00);
  localparam logic [2:0] SMASK = {1'b1, ~PMASK};

  function automatic logic is_locked(input logic [15:0] nvc);
    is_locked = nvc[tsense_pkg::LOCK_POS] |
      nvc[tsense_pkg::LOCKDOWN_POS];
  endfunction

  function automatic logic ee_match(input logic [7:0] b,
                                    input logic [2:0] strap);
    ee_match = (b[7:4] == tsense_pkg::EE_TYPE) &&
      (((b[3:1] ^ strap) & SMASK) == 3'h0);
  endfunction

  // ----------------------------------------------------------------
  // link domain: sample sda on each rising scl
  // ----------------------------------------------------------------
  typedef struct packed {
    logic bit_v;
    logic tgl;
  } link_t;

  link_t lk_q;
  link_t lk_d;

  always_comb
  begin
    lk_d.bit_v = sda_in;
    lk_d.tgl = ~lk_q.tgl;
  end

  // scl may stop between frames, so this side holds no protocol state
  always_ff @(posedge scl_in or posedge srst_in)
  begin
    if (srst_in)
      lk_q <= '0;
    else
      lk_q <= lk_d;
  end

  // ----------------------------------------------------------------
  // system domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic t1;
    logic t2;
    logic t3;
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
    tsense_pkg::link_st_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic ack_on;
    logic cmd_byte;
    logic is_ee;
    tsense_pkg::copy_op_t pend;
    tsense_pkg::copy_op_t run;
    logic [tsense_pkg::TMR_W-1:0] tmr;
    logic [15:0] cfg;
    logic [15:0] low;
    logic [15:0] high;
    logic oe;
    logic nvw;
    logic ptrl;
    logic [7:0] ptr;
    logic ees;
    logic eerw;
    logic [1:0] eep;
  } state_t;

  localparam state_t RST = '{
    t1: 1'b0, t2: 1'b0, t3: 1'b0,
    scl1: 1'b1, scl2: 1'b1, scl3: 1'b1,
    sda1: 1'b1, sda2: 1'b1, sda3: 1'b1,
    st: tsense_pkg::ST_IDLE, cnt: 4'h0, sh: 8'h00,
    ack_on: 1'b0, cmd_byte: 1'b0, is_ee: 1'b0,
    pend: tsense_pkg::OP_NONE,
    run: tsense_pkg::OP_RD,
    tmr: tsense_pkg::TMR_W'(COPYR_CYCLES - 1),
    cfg: tsense_pkg::VOL_RST,
    low: tsense_pkg::VOL_RST,
    high: tsense_pkg::VOL_RST,
    oe: 1'b0, nvw: 1'b0, ptrl: 1'b0, ptr: 8'h00,
    ees: 1'b0, eerw: 1'b0, eep: 2'h0
  };

  state_t q;
  state_t d;
  logic sample;
  logic fall;
  logic start;
  logic stop;
  logic busy;
  logic byte_done;
  logic [7:0] byte_v;

  always_comb
  begin
    d = q;
    d.t1 = lk_q.tgl;
    d.t2 = q.t1;
    d.t3 = q.t2;
    d.scl1 = scl_in;
    d.scl2 = q.scl1;
    d.scl3 = q.scl2;
    d.sda1 = sda_in;
    d.sda2 = q.sda1;
    d.sda3 = q.sda2;
    d.nvw = 1'b0;
    d.ptrl = 1'b0;
    d.ees = 1'b0;
    // bit_v was settled well before its toggle got through the sync
    sample = q.t2 ^ q.t3;
    fall = q.scl3 & ~q.scl2;
    start = q.scl2 & q.scl3 & q.sda3 & ~q.sda2;
    stop = q.scl2 & q.scl3 & ~q.sda3 & q.sda2;
    busy = (q.run != tsense_pkg::OP_NONE);
    byte_v = {q.sh[6:0], lk_q.bit_v};
    byte_done = (q.st == tsense_pkg::ST_RECV) && sample &&
      (q.cnt == 4'h7);

    // copy engine
    if (busy)
    begin
      if (q.tmr == '0)
      begin
        if (q.run == tsense_pkg::OP_RD)
        begin
          d.cfg = nv_cfg_in;
          d.low = nv_low_in;
          d.high = nv_high_in;
        end
        d.run = tsense_pkg::OP_NONE;
      end
      else
        d.tmr = q.tmr - 1'b1;
    end
    else if (vol_load_in && !is_locked(nv_cfg_in))
    begin
      d.cfg = vol_cfg_in;
      d.low = vol_low_in;
      d.high = vol_high_in;
    end

    // ----------------------------------------------------------------
    // bus conditions and byte handling
    // ----------------------------------------------------------------
    if (start)
    begin
      d.pend = tsense_pkg::OP_NONE;
      d.st = tsense_pkg::ST_RECV;
      d.cnt = 4'h0;
      d.cmd_byte = 1'b0;
      d.ack_on = 1'b0;
      d.oe = 1'b0;
    end
    else if (stop)
    begin
      if (q.pend != tsense_pkg::OP_NONE)
      begin
        d.run = q.pend;
        if (q.pend == tsense_pkg::OP_WR)
        begin
          d.tmr = tsense_pkg::TMR_W'(COPYW_CYCLES - 1);
          d.nvw = 1'b1;
        end
        else
          d.tmr = tsense_pkg::TMR_W'(COPYR_CYCLES - 1);
      end
      d.pend = tsense_pkg::OP_NONE;
      d.st = tsense_pkg::ST_IDLE;
      d.oe = 1'b0;
      d.ack_on = 1'b0;
    end
    else
    begin
      unique case (q.st)
        tsense_pkg::ST_IDLE,
        tsense_pkg::ST_SKIP:
        begin
        end
        tsense_pkg::ST_RECV:
        begin
          if (sample)
          begin
            d.sh = byte_v;
            d.cnt = q.cnt + 4'h1;
          end
          if (byte_done)
          begin
            d.st = tsense_pkg::ST_ACK;
            d.ack_on = 1'b0;
            if (q.cmd_byte)
            begin
              // opcode bytes are acked even when ignored
              if (byte_v == tsense_pkg::OP_NV2VOL ||
                  byte_v == tsense_pkg::OP_VOL2NV)
              begin
                if (!busy && !is_locked(nv_cfg_in))
                  d.pend = (byte_v == tsense_pkg::OP_NV2VOL) ?
                    tsense_pkg::OP_RD : tsense_pkg::OP_WR;
              end
              else
              begin
                d.ptr = byte_v;
                d.ptrl = 1'b1;
              end
            end
            else if (byte_v[7:4] == tsense_pkg::SENSOR_TYPE &&
                     byte_v[3:1] == strap_address_bits_in &&
                     !byte_v[0])
              d.is_ee = 1'b0;
            else if (ee_match(byte_v, strap_address_bits_in) && !busy)
            begin
              d.is_ee = 1'b1;
              d.ees = 1'b1;
              d.eerw = byte_v[0];
              d.eep = byte_v[2:1] & PMASK;
            end
            else
              d.st = tsense_pkg::ST_SKIP;
          end
        end
        tsense_pkg::ST_ACK:
        begin
          // drive low from the 8th falling edge to the 9th
          if (fall)
          begin
            if (!q.ack_on)
            begin
              d.ack_on = 1'b1;
              d.oe = 1'b1;
            end
            else
            begin
              d.ack_on = 1'b0;
              d.oe = 1'b0;
              d.cnt = 4'h0;
              if (q.is_ee || q.cmd_byte)
                d.st = tsense_pkg::ST_SKIP;
              else
              begin
                d.st = tsense_pkg::ST_RECV;
                d.cmd_byte = 1'b1;
              end
            end
          end
        end
      endcase
    end
    d.cfg[tsense_pkg::BUSY_POS] = (d.run != tsense_pkg::OP_NONE);
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      q <= RST;
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sda_out = 1'b0;
  assign sda_oe_out = q.oe;
  assign vol_cfg_out = q.cfg;
  assign lower_temp_limit_out = q.low;
  assign upper_temp_limit_out = q.high;
  assign nv_busy_flag_out = q.cfg[tsense_pkg::BUSY_POS];
  assign nv_write_out = q.nvw;
  assign ptr_load_out = q.ptrl;
  assign ptr_byte_out = q.ptr;
  assign ee_select_out = q.ees;
  assign ee_rw_out = q.eerw;
  assign ee_page_out = q.eep;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  a_reset_copy: assert property (
    $fell(srst_in) |-> q.run == tsense_pkg::OP_RD ##1 nv_busy_flag_out)
    else $error("no copy after reset");
  a_launch_busy: assert property (
    (stop && q.pend != tsense_pkg::OP_NONE) |=> nv_busy_flag_out)
    else $error("busy not set on copy launch");
  a_abort_copy: assert property (
    (start && q.pend != tsense_pkg::OP_NONE && !busy) |=>
      !nv_busy_flag_out ##1 !nv_busy_flag_out)
    else $error("aborted copy still ran");
  a_lock_ignore: assert property (
    (byte_done && q.cmd_byte && (busy || is_locked(nv_cfg_in))) |=>
      q.pend == $past(q.pend))
    else $error("copy accepted while busy or locked");
  a_opcode_ack: assert property (
    (byte_done && q.cmd_byte) |=> q.st == tsense_pkg::ST_ACK)
    else $error("opcode byte not acknowledged");
  a_ptr_keep: assert property (
    (byte_done && q.cmd_byte && (byte_v == tsense_pkg::OP_NV2VOL ||
      byte_v == tsense_pkg::OP_VOL2NV)) |=>
      !ptr_load_out && $stable(ptr_byte_out))
    else $error("opcode disturbed the pointer");
  a_nv_write: assert property (
    nv_write_out |-> $rose(nv_busy_flag_out) &&
      q.run == tsense_pkg::OP_WR)
    else $error("nonvolatile write without busy");
  a_rd_load: assert property (
    (q.run == tsense_pkg::OP_RD && q.tmr == '0) |=>
      lower_temp_limit_out == $past(nv_low_in) &&
      upper_temp_limit_out == $past(nv_high_in) && !nv_busy_flag_out)
    else $error("volatile load wrong at copy end");
  a_ee_select: assert property (
    ee_select_out |-> q.sh[7:4] == tsense_pkg::EE_TYPE &&
      ((q.sh[3:1] ^ strap_address_bits_in) & SMASK) == 3'h0)
    else $error("eeprom selected on mismatched straps");
  a_ee_page: assert property (
    ee_select_out |-> ee_page_out == (q.sh[2:1] & PMASK) &&
      {ee_page_out, 4'h0} < EE_PAGES)
    else $error("eeprom page bits wrong");
  a_ack_slot: assert property (
    $rose(sda_oe_out) |-> q.st == tsense_pkg::ST_ACK && !sda_out)
    else $error("sda driven outside ack slot");

  c_copy_rd: cover property (nv_busy_flag_out &&
    q.run == tsense_pkg::OP_RD && $past(stop));
  c_copy_wr: cover property (nv_write_out);
  c_abort: cover property (start && q.pend != tsense_pkg::OP_NONE);
  c_ee_sel: cover property (ee_select_out);

endmodule

`default_nettype wire

// File: twi_ctrl_model.sv
// two-wire bus controller model that issues sensor commands
`timescale 1ns/100ps
`default_nettype none
module twi_ctrl_model (
  output logic scl_out,
  output logic sda_oe_out,
  input wire logic sda_in,
  output logic ack_out,
  output logic [7:0] ack_n_out
);
  // ----------------------------------------------------------------
  // frame primitives
  // ----------------------------------------------------------------
  localparam int HP = 260;
  localparam int Q = 80;
  initial
  begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
    ack_out = 1'b0;
    ack_n_out = 8'h00;
  end
  // clock stands high between frames; odd offset keeps phase unrelated
  task automatic start_c();
    #(HP + 7) sda_oe_out = 1'b1;
    #HP scl_out = 1'b0;
  endtask
  // sda is released only while clock is low, so no false stop is seen
  task automatic rstart_c();
    #Q sda_oe_out = 1'b0;
    #(HP - Q) scl_out = 1'b1;
    #HP sda_oe_out = 1'b1;
    #HP scl_out = 1'b0;
  endtask
  task automatic stop_c();
    #Q sda_oe_out = 1'b1;
    #(HP - Q) scl_out = 1'b1;
    #HP sda_oe_out = 1'b0;
    #HP;
  endtask
  task automatic byte_c(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      #Q sda_oe_out = ~b[i];
      #(HP - Q) scl_out = 1'b1;
      #HP scl_out = 1'b0;
    end
    #Q sda_oe_out = 1'b0;
    #(HP - Q) scl_out = 1'b1;
    #(HP / 2) ack_out = ~sda_in;
    ack_n_out = ack_n_out + 8'h01;
    #(HP / 2) scl_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: nv_copy_and_eeprom_addressing_tb_top.sv
// self-checking bench for the register-copy command logic
`timescale 1ns/100ps
`default_nettype none
module nv_copy_and_eeprom_addressing_tb_top;
  // ----------------------------------------------------------------
  // environment
  // ----------------------------------------------------------------
  localparam int CR = 20;
  localparam int CW = 600;
  localparam logic [2:0] STRAP = 3'b101;
  localparam logic [7:0] SA = {tsense_pkg::SENSOR_TYPE, STRAP, 1'b0};
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic vol_load = 1'b0;
  logic m_scl, m_oe, m_ack, sda_oe, sda_o, nvw, ptr_ld, ee_sel, ee_rw, busy;
  logic busy_p = 1'b0;
  logic [1:0] ee_page;
  logic [3:0] kb;
  logic [7:0] m_ack_n, ptr_byte, pb;
  logic [7:0] ack_seen = 8'h00;
  logic [15:0] nv_cfg, nv_low, nv_high, o_cfg, o_low, o_high;
  logic [15:0] v_cfg, v_low, v_high;
  logic [47:0] keep;
  logic [31:0] lfsr = 32'h800d;
  logic [63:0] ack_q[$], copy_q[$], nvw_q[$], ptr_q[$], ee_q[$];
  int n_fail = 0;
  int samples_checked = 0;
  int busy_n = 0;
  wire sda = ~(m_oe | (sda_oe & ~sda_o));

  always #20 mclk_in = ~mclk_in;

  tsense_copy_ctrl #(.EE_BYTES(512), .COPYR_CYCLES(CR), .COPYW_CYCLES(CW))
  dut_u (
    .mclk_in(mclk_in), .srst_in(srst_in), .scl_in(m_scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .strap_address_bits_in(STRAP),
    .nv_cfg_in(nv_cfg), .nv_low_in(nv_low), .nv_high_in(nv_high),
    .vol_load_in(vol_load), .vol_cfg_in(v_cfg), .vol_low_in(v_low),
    .vol_high_in(v_high), .vol_cfg_out(o_cfg),
    .lower_temp_limit_out(o_low), .upper_temp_limit_out(o_high),
    .nv_busy_flag_out(busy), .nv_write_out(nvw), .ptr_load_out(ptr_ld),
    .ptr_byte_out(ptr_byte), .ee_select_out(ee_sel), .ee_rw_out(ee_rw),
    .ee_page_out(ee_page)
  );
  twi_ctrl_model master_u (
    .scl_out(m_scl), .sda_oe_out(m_oe), .sda_in(sda), .ack_out(m_ack),
    .ack_n_out(m_ack_n)
  );

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[15:0];
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // a result with no note waiting is itself a mismatch
  task automatic take(input int k, input logic [63:0] seen);
    logic [63:0] e;
    logic hit;
    hit = 1'b1;
    if (k == 0 && ack_q.size() > 0) e = ack_q.pop_front();
    else if (k == 1 && copy_q.size() > 0) e = copy_q.pop_front();
    else if (k == 2 && nvw_q.size() > 0) e = nvw_q.pop_front();
    else if (k == 3 && ptr_q.size() > 0) e = ptr_q.pop_front();
    else if (k == 4 && ee_q.size() > 0) e = ee_q.pop_front();
    else hit = 1'b0;
    check(hit ? seen : 64'h1, hit ? e : 64'h0);
  endtask
  task automatic frame(input logic [7:0] a, input logic [7:0] op,
                       input logic ea, input logic two, input logic ab);
    master_u.start_c();
    ack_q.push_back(64'(ea));
    master_u.byte_c(a);
    if (ea && two)
    begin
      ack_q.push_back(64'h1);
      master_u.byte_c(op);
    end
    if (ab) master_u.rstart_c();
    master_u.stop_c();
    @(negedge mclk_in);
  endtask
  task automatic wait_idle();
    repeat (3) @(negedge mclk_in);
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge mclk_in);
  endtask

  // ----------------------------------------------------------------
  // output watcher
  // ----------------------------------------------------------------
  always @(negedge mclk_in)
  begin
    if (m_ack_n !== ack_seen)
    begin
      ack_seen = m_ack_n;
      take(0, 64'(m_ack));
    end
    if (busy === 1'b1) busy_n++;
    if (busy_p && busy === 1'b0)
    begin
      take(1, {16'(busy_n), o_cfg, o_low, o_high});
      busy_n = 0;
    end
    busy_p = busy;
    if (nvw === 1'b1) take(2, 64'({o_cfg[15:1], o_low, o_high}));
    if (ptr_ld === 1'b1) take(3, 64'(ptr_byte));
    if (ee_sel === 1'b1) take(4, 64'({ee_rw, ee_page}));
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    v_cfg = 16'h0000;
    v_low = 16'h0000;
    v_high = 16'h0000;
    nv_cfg = rnd() & 16'hfff8;
    nv_low = rnd();
    nv_high = rnd();
    // the cycle still held in reset is the copy's first, so busy shows one less
    copy_q.push_back({16'(CR - 1), nv_cfg, nv_low, nv_high});
    repeat (12) @(negedge mclk_in);
    srst_in = 1'b0;
    wait_idle();
    for (int k = 0; k < 4; k++)
      frame(SA ^ (8'h01 << k), 8'h00, 1'b0, 1'b0, 1'b0);
    nv_cfg = rnd() & 16'hfff8;
    nv_low = rnd();
    nv_high = rnd();
    copy_q.push_back({16'(CR), nv_cfg, nv_low, nv_high});
    frame(SA, tsense_pkg::OP_NV2VOL, 1'b1, 1'b1, 1'b0);
    wait_idle();
    v_cfg = rnd() & 16'hfffe;
    v_low = rnd();
    v_high = rnd();
    vol_load = 1'b1;
    @(negedge mclk_in);
    vol_load = 1'b0;
    nvw_q.push_back(64'({v_cfg[15:1], v_low, v_high}));
    copy_q.push_back({16'(CW), v_cfg, v_low, v_high});
    frame(SA, tsense_pkg::OP_VOL2NV, 1'b1, 1'b1, 1'b0);
    frame(SA, tsense_pkg::OP_NV2VOL, 1'b1, 1'b1, 1'b0);
    wait_idle();
    keep = {v_cfg, v_low, v_high};
    nv_low = rnd();
    frame(SA, tsense_pkg::OP_NV2VOL, 1'b1, 1'b1, 1'b1);
    frame(SA, tsense_pkg::OP_VOL2NV, 1'b1, 1'b1, 1'b1);
    for (int k = 0; k < 2; k++)
    begin
      nv_cfg = 16'h1 << (k ? tsense_pkg::LOCKDOWN_POS : tsense_pkg::LOCK_POS);
      frame(SA, tsense_pkg::OP_NV2VOL, 1'b1, 1'b1, 1'b0);
      frame(SA, tsense_pkg::OP_VOL2NV, 1'b1, 1'b1, 1'b0);
      v_high = rnd();
      vol_load = 1'b1;
      @(negedge mclk_in);
      vol_load = 1'b0;
    end
    check(64'({o_cfg, o_low, o_high}), 64'(keep));
    nv_cfg = 16'h0000;
    pb = 8'(rnd() & 16'h000f);
    ptr_q.push_back(64'(pb));
    frame(SA, pb, 1'b1, 1'b1, 1'b0);
    for (int k = 0; k < 16; k++)
    begin
      kb = 4'(k);
      if (kb[3:2] == STRAP[2:1]) ee_q.push_back(64'({kb[0], 1'b0, kb[1]}));
      frame({tsense_pkg::EE_TYPE, kb}, 8'h00, kb[3:2] == STRAP[2:1],
            1'b0, 1'b0);
    end
    // a second reset in mid-run must reload the volatile copy as well
    nv_cfg = rnd() & 16'hfff8;
    nv_low = rnd();
    nv_high = rnd();
    copy_q.push_back({16'(CR - 1), nv_cfg, nv_low, nv_high});
    srst_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    srst_in = 1'b0;
    wait_idle();
    repeat (10) @(negedge mclk_in);
    check(64'(ack_q.size() + copy_q.size() + nvw_q.size() + ptr_q.size()
          + ee_q.size()), 64'h0);
    report_and_stop();
  end

  initial
  begin
    #1000000;
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
